// ===== rtl/boc_controller.sv
// Byte operation controller: decode, datapath strobes, ALU and APB registers
//
// How it works
// - Decode instruction register word and drive datapath controls for it.
// - Add sums accumulator and file; d=0 to accumulator, d=1 to file.
// - Add updates zero, carry and digit carry flags from its result.
// - File field zero takes address from indirect pointer, else field directly.
// - Second operand from special register path below address 8, else RAM.
// - Address select picks direct address unless field hits indirect slot.
// - All controls set on falling edge; target captures on next rising edge.
// - Same cycle strobes instruction latch and advances the program counter.
// - Target strobe chosen from opcode and destination field; address from file field and pointer.
// - All file registers take the result bus; one strobe picks destination.
// - Flag values and matching flag strobes presented per instruction word.
// - AND ands accumulator with file, stores per d, updates zero only.
// - All file/destination instructions share one setup and target routine.
// - Clear-file writes zero to addressed file, sets zero flag only.
// - Clear-file handled as destination bit fixed at one.
// - Status register as target suppresses flag write strobes.
`timescale 1ns/10ps
module boc_controller
  import boc_pkg::*;
#(
  parameter int PTR_W = BOC_DW
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [BOC_IW-1:0] instr_word_bus_i,
  input  wire logic [PTR_W-1:0]  indirect_pointer_register_i,
  input  wire logic [BOC_DW-1:0] accumulator_i,
  input  wire logic [BOC_DW-1:0] sfr_data_i,
  input  wire logic [BOC_DW-1:0] ram_data_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [BOC_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output boc_ctrl_t              ctrl_o
);

  function automatic boc_op_t decode_op(input logic [BOC_IW-1:0] w);
    if ((w & BOC_MASK_FD) == BOC_ADD_VAL) begin
      return BOC_OP_ADD;
    end else if ((w & BOC_MASK_FD) == BOC_AND_VAL) begin
      return BOC_OP_AND;
    end else if ((w & BOC_MASK_F) == BOC_CLEAR_FILE_VAL) begin
      return BOC_OP_CLR;
    end
    return BOC_OP_NONE;
  endfunction

  // Effective file address: pointer when the field names the indirect slot
  function automatic logic [BOC_FW-1:0] eff_addr(input logic [BOC_IW-1:0] w,
                                                 input logic [PTR_W-1:0]  p);
    if (w[BOC_FW-1:0] == BOC_INDIRECT_SLOT) begin
      return p[BOC_FW-1:0];
    end
    return w[BOC_FW-1:0];
  endfunction

  function automatic logic dest_file(input logic [BOC_IW-1:0] w);
    return (decode_op(w) == BOC_OP_CLR) ? 1'b1 : w[BOC_D_BIT];
  endfunction

  boc_state_t        state_ff;
  boc_state_t        nxt_state;
  boc_ctrl_t         ctrl_ff;
  boc_ctrl_t         nxt_ctrl;
  logic              run_ff;
  logic              nxt_run;
  logic [31:0]       count_ff;
  logic [31:0]       nxt_count;
  boc_op_t           last_op_ff;
  boc_op_t           nxt_last_op;
  logic [31:0]       prdata_ff;
  logic [31:0]       nxt_prdata;
  logic              pready_ff;
  logic              nxt_pready;
  logic              pslverr_ff;
  logic              nxt_pslverr;
  boc_op_t           cur_op;
  logic [BOC_FW-1:0] cur_addr;
  logic              cur_dest;
  logic [BOC_DW-1:0] operand;
  logic [BOC_DW:0]   sum_wide;
  logic [BOC_NIB:0]  nib_sum;

  assign cur_op   = decode_op(instr_word_bus_i);
  assign cur_addr = eff_addr(instr_word_bus_i, indirect_pointer_register_i);
  assign cur_dest = dest_file(instr_word_bus_i);
  assign operand  = (cur_addr < BOC_SFR_LIMIT) ? sfr_data_i : ram_data_i;
  assign sum_wide = {1'b0, accumulator_i} + {1'b0, operand};
  assign nib_sum  = {1'b0, accumulator_i[BOC_NIB-1:0]} + {1'b0, operand[BOC_NIB-1:0]};

  // Execution controls, set up on the falling edge
  always_comb begin
    nxt_ctrl = BOC_CTRL_IDLE;
    if (state_ff == BOC_EXEC) begin
      nxt_ctrl.instr_latch_strobe = 1'b1;
      nxt_ctrl.counter_advance    = 1'b1;
      if (cur_op != BOC_OP_NONE) begin
        // Shared target load routine for every file/destination op
        nxt_ctrl.addr_indirect =
          (instr_word_bus_i[BOC_FW-1:0] == BOC_INDIRECT_SLOT);
        nxt_ctrl.file_addr   = cur_addr;
        nxt_ctrl.operand_sfr = (cur_addr < BOC_SFR_LIMIT);
        nxt_ctrl.acc_write   = ~cur_dest;
        nxt_ctrl.file_write  = cur_dest;
        case (cur_op)
          BOC_OP_ADD: begin
            nxt_ctrl.result                 = sum_wide[BOC_DW-1:0];
            nxt_ctrl.flag_write             = BOC_FLAGS_ALL;
            nxt_ctrl.flag_value[BOC_FLAG_C] = sum_wide[BOC_DW];
            nxt_ctrl.flag_value[BOC_FLAG_DC] = nib_sum[BOC_NIB];
          end
          BOC_OP_AND: begin
            nxt_ctrl.result     = accumulator_i & operand;
            nxt_ctrl.flag_write = BOC_FLAGS_Z;
          end
          BOC_OP_CLR: begin
            nxt_ctrl.result     = BOC_CLEAR_VALUE;
            nxt_ctrl.flag_write = BOC_FLAGS_Z;
          end
          default: begin
            nxt_ctrl.result = BOC_CLEAR_VALUE;
          end
        endcase
        nxt_ctrl.flag_value[BOC_FLAG_Z] = (nxt_ctrl.result == BOC_CLEAR_VALUE);
        if (cur_dest && cur_addr == BOC_STATUS_ADDR) begin
          nxt_ctrl.flag_write = BOC_FLAGS_NONE;
        end
      end
    end
  end

  always_ff @(negedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= BOC_CTRL_IDLE;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Run state and execution bookkeeping on the rising edge
  always_comb begin
    nxt_state   = state_ff;
    nxt_count   = count_ff;
    nxt_last_op = last_op_ff;
    case (state_ff)
      BOC_HALT: begin
        if (run_ff) begin
          nxt_state = BOC_EXEC;
        end
      end
      BOC_EXEC: begin
        if (!run_ff) begin
          nxt_state = BOC_HALT;
        end
      end
      default: begin
        nxt_state = BOC_HALT;
      end
    endcase
    if (ctrl_ff.instr_latch_strobe) begin
      nxt_count   = count_ff + 32'h0000_0001;
      nxt_last_op = cur_op;
    end
  end

  // APB slave: one wait-free access phase, error on unmapped offsets
  always_comb begin
    nxt_run     = run_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = psel_i && !penable_i;
    nxt_pslverr = 1'b0;
    if (psel_i && !penable_i) begin
      nxt_prdata = BOC_RD_ZERO;
      case (paddr_i)
        BOC_ADDR_CTRL: begin
          nxt_prdata[BOC_CTRL_RUN_BIT] = run_ff;
        end
        BOC_ADDR_STAT: begin
          nxt_prdata[2:0] = {last_op_ff, state_ff};
        end
        BOC_ADDR_COUNT: begin
          nxt_prdata = count_ff;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    if (psel_i && penable_i && pready_ff && pwrite_i && paddr_i == BOC_ADDR_CTRL) begin
      nxt_run = pwdata_i[BOC_CTRL_RUN_BIT];
    end
    if (psel_i && penable_i && pready_ff) begin
      nxt_pslverr = 1'b0;
    end else if (!(psel_i && !penable_i)) begin
      nxt_pslverr = pslverr_ff;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= BOC_HALT;
      count_ff   <= 32'h0000_0000;
      last_op_ff <= BOC_OP_NONE;
      run_ff     <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      count_ff   <= nxt_count;
      last_op_ff <= nxt_last_op;
      run_ff     <= nxt_run;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign ctrl_o    = ctrl_ff;
  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;

  // Checks, sampled on the rising edge after each falling-edge setup
  default clocking chk_cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence run_request_s;
    !run_ff ##1 run_ff;
  endsequence

  sequence halted_s;
    !run_ff ##1 (state_ff == BOC_HALT);
  endsequence

  fetch_start_a: assert property (run_request_s |-> ##[1:2] ctrl_o.instr_latch_strobe)
    else $error("Fetch did not start after run was set");

  fetch_pair_a: assert property (ctrl_o.instr_latch_strobe == ctrl_o.counter_advance)
    else $error("Latch and counter advance not paired");

  halt_quiet_a: assert property (halted_s ##1 (state_ff == BOC_HALT) |->
      !ctrl_o.instr_latch_strobe && !ctrl_o.acc_write && !ctrl_o.file_write
      && ctrl_o.flag_write == BOC_FLAGS_NONE)
    else $error("Strobe active while halted");

  add_dest_a: assert property (ctrl_o.instr_latch_strobe && cur_op == BOC_OP_ADD |->
      ctrl_o.file_write == instr_word_bus_i[BOC_D_BIT]
      && ctrl_o.result == sum_wide[BOC_DW-1:0])
    else $error("Add destination or sum wrong");

  add_flags_a: assert property (ctrl_o.instr_latch_strobe && cur_op == BOC_OP_ADD
      && !(ctrl_o.file_write && ctrl_o.file_addr == BOC_STATUS_ADDR)
      |-> ctrl_o.flag_write == BOC_FLAGS_ALL && ctrl_o.flag_value[BOC_FLAG_C] == sum_wide[BOC_DW])
    else $error("Add flags wrong");

  and_flags_a: assert property (ctrl_o.instr_latch_strobe && cur_op == BOC_OP_AND
      && !(ctrl_o.file_write && ctrl_o.file_addr == BOC_STATUS_ADDR)
      |-> ctrl_o.flag_write == BOC_FLAGS_Z && ctrl_o.result == (accumulator_i & operand))
    else $error("And result or flags wrong");

  clear_file_a: assert property (ctrl_o.instr_latch_strobe && cur_op == BOC_OP_CLR |->
      ctrl_o.file_write && !ctrl_o.acc_write && ctrl_o.result == BOC_CLEAR_VALUE
      && ctrl_o.flag_value[BOC_FLAG_Z])
    else $error("Clear file wrong");

  indirect_addr_a: assert property (ctrl_o.file_write || ctrl_o.acc_write |->
      ctrl_o.addr_indirect == (instr_word_bus_i[BOC_FW-1:0] == BOC_INDIRECT_SLOT)
      && ctrl_o.file_addr == cur_addr)
    else $error("Address select wrong");

  operand_sel_a: assert property (ctrl_o.file_write || ctrl_o.acc_write |->
      ctrl_o.operand_sfr == (ctrl_o.file_addr < BOC_SFR_LIMIT))
    else $error("Operand source wrong");

  status_prec_a: assert property (ctrl_o.file_write && ctrl_o.file_addr == BOC_STATUS_ADDR
      |-> ctrl_o.flag_write == BOC_FLAGS_NONE)
    else $error("Flag strobes with status as target");

  one_target_a: assert property (!(ctrl_o.acc_write && ctrl_o.file_write))
    else $error("Two targets strobed");

  count_step_a: assert property (ctrl_o.instr_latch_strobe |=> count_ff == $past(count_ff) + 32'h0000_0001)
    else $error("Execution count did not advance");

endmodule

// ===== rtl/boc_pkg.sv
// Constants and types shared by the byte operation controller
package boc_pkg;

  localparam int BOC_IW = 12;
  localparam int BOC_FW = 5;
  localparam int BOC_DW = 8;
  localparam int BOC_AW = 8;
  localparam int BOC_NIB = 4;

  // Opcode match masks and values
  localparam logic [11:0] BOC_MASK_FD  = 12'hfc0;
  localparam logic [11:0] BOC_MASK_F   = 12'hfe0;
  localparam logic [11:0] BOC_ADD_VAL  = 12'h1c0;
  localparam logic [11:0] BOC_AND_VAL  = 12'h140;
  localparam logic [11:0] BOC_CLEAR_FILE_VAL = 12'h060;

  localparam int BOC_D_BIT = 5;

  localparam logic [4:0] BOC_INDIRECT_SLOT = 5'h00;
  localparam logic [4:0] BOC_SFR_LIMIT     = 5'h08;
  localparam logic [4:0] BOC_STATUS_ADDR   = 5'h03;
  localparam logic [7:0] BOC_CLEAR_VALUE   = 8'h00;

  localparam int BOC_FLAG_C  = 0;
  localparam int BOC_FLAG_DC = 1;
  localparam int BOC_FLAG_Z  = 2;
  localparam logic [2:0] BOC_FLAGS_ALL  = 3'h7;
  localparam logic [2:0] BOC_FLAGS_Z    = 3'h4;
  localparam logic [2:0] BOC_FLAGS_NONE = 3'h0;

  // Register map
  localparam logic [7:0] BOC_ADDR_CTRL  = 8'h00;
  localparam logic [7:0] BOC_ADDR_STAT  = 8'h04;
  localparam logic [7:0] BOC_ADDR_COUNT = 8'h08;
  localparam int BOC_CTRL_RUN_BIT = 0;
  localparam logic [31:0] BOC_RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {BOC_OP_NONE, BOC_OP_ADD, BOC_OP_AND, BOC_OP_CLR} boc_op_t;
  typedef enum logic {BOC_HALT, BOC_EXEC} boc_state_t;

  typedef struct packed {
    logic       acc_write;
    logic       file_write;
    logic       addr_indirect;
    logic       operand_sfr;
    logic [4:0] file_addr;
    logic [2:0] flag_write;
    logic [2:0] flag_value;
    logic [7:0] result;
    logic       instr_latch_strobe;
    logic       counter_advance;
  } boc_ctrl_t;

  localparam boc_ctrl_t BOC_CTRL_IDLE = '0;

endpackage

// ===== tb/boc_datapath_model.sv
// Behavioural core datapath facing the byte operation controller
`timescale 1ns/10ps
module boc_datapath_model
  import boc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [BOC_IW-1:0] fetch_word_i,
  input  wire logic [BOC_DW-1:0] ptr_i,
  input  wire logic [BOC_DW-1:0] file_val_i,
  input  wire boc_ctrl_t         ctrl_i,
  output logic      [BOC_IW-1:0] instr_word_bus_o,
  output logic      [BOC_DW-1:0] sfr_data_o,
  output logic      [BOC_DW-1:0] ram_data_o,
  output logic      [BOC_DW-1:0] stored_o
);
  logic [BOC_IW-1:0] ir_ff;
  logic [BOC_DW-1:0] stored_ff;
  logic [4:0]        eff_addr;

  assign eff_addr = (ir_ff[4:0] == BOC_INDIRECT_SLOT) ? ptr_i[4:0] : ir_ff[4:0];
  // Unselected path shows inverted data, never the real operand
  assign sfr_data_o = (eff_addr < BOC_SFR_LIMIT) ? file_val_i : ~file_val_i;
  assign ram_data_o = (eff_addr < BOC_SFR_LIMIT) ? ~file_val_i : file_val_i;
  assign instr_word_bus_o = ir_ff;
  assign stored_o = stored_ff;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ir_ff <= '0;
      stored_ff <= '0;
    end else begin
      if (ctrl_i.instr_latch_strobe) begin
        ir_ff <= fetch_word_i;
      end
      // Result bus captured on the rising edge into the strobed target
      if (ctrl_i.acc_write || ctrl_i.file_write) begin
        stored_ff <= ctrl_i.result;
      end
    end
  end
endmodule

// ===== tb/tb_byte_op_controller.sv
// Self-checking testbench for the byte operation controller
`timescale 1ns/10ps
module tb_byte_op_controller import boc_pkg::*;;
  typedef struct packed {
    logic [11:0] instr;
    logic [7:0]  ptr;
    logic [7:0]  acc;
    logic [7:0]  fv;
    logic        aw;
    logic        fw;
    logic        ind;
    logic        sfr;
    logic [4:0]  addr;
    logic [2:0]  flw;
    logic [2:0]  flv;
    logic [7:0]  res;
  } boc_row_t;

  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, ptr, acc, fval, sfr_d, ram_d, stored;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] fetch, iw;
  boc_ctrl_t   ctrl;
  int          bad_count = 0;
  int          n_tests = 0;
  boc_row_t    rows [11] = '{
    '{12'h1d0, 8'h00, 8'h0f, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0, 5'h10, 3'h7, 3'h2, 8'h10},
    '{12'h1e5, 8'h00, 8'h80, 8'h80, 1'b0, 1'b1, 1'b0, 1'b1, 5'h05, 3'h7, 3'h5, 8'h00},
    '{12'h1e0, 8'hff, 8'h12, 8'h34, 1'b0, 1'b1, 1'b1, 1'b0, 5'h1f, 3'h7, 3'h0, 8'h46},
    '{12'h147, 8'h00, 8'hf0, 8'h3c, 1'b1, 1'b0, 1'b0, 1'b1, 5'h07, 3'h4, 3'h0, 8'h30},
    '{12'h168, 8'h00, 8'h0f, 8'hf0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h08, 3'h4, 3'h4, 8'h00},
    '{12'h140, 8'h02, 8'haa, 8'hff, 1'b1, 1'b0, 1'b1, 1'b1, 5'h02, 3'h4, 3'h0, 8'haa},
    '{12'h06a, 8'h00, 8'h55, 8'h77, 1'b0, 1'b1, 1'b0, 1'b0, 5'h0a, 3'h4, 3'h4, 8'h00},
    '{12'h060, 8'h09, 8'h55, 8'h77, 1'b0, 1'b1, 1'b1, 1'b0, 5'h09, 3'h4, 3'h4, 8'h00},
    '{12'h1e3, 8'h00, 8'h01, 8'h02, 1'b0, 1'b1, 1'b0, 1'b1, 5'h03, 3'h0, 3'h0, 8'h03},
    '{12'h063, 8'h00, 8'h01, 8'h02, 1'b0, 1'b1, 1'b0, 1'b1, 5'h03, 3'h0, 3'h0, 8'h00},
    '{12'h1c3, 8'h00, 8'hff, 8'h01, 1'b1, 1'b0, 1'b0, 1'b1, 5'h03, 3'h7, 3'h7, 8'h00}};

  boc_controller dut (
    .clock_i(clk), .rst_i(rst), .instr_word_bus_i(iw), .indirect_pointer_register_i(ptr),
    .accumulator_i(acc), .sfr_data_i(sfr_d), .ram_data_i(ram_d), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ctrl_o(ctrl));

  boc_datapath_model dp (
    .clock_i(clk), .rst_i(rst), .fetch_word_i(fetch), .ptr_i(ptr), .file_val_i(fval),
    .ctrl_i(ctrl), .instr_word_bus_o(iw), .sfr_data_o(sfr_d), .ram_data_o(ram_d),
    .stored_o(stored));

  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave's answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    $display("[ERR] watchdog expired");
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fetch = 12'h000;
    ptr = 8'h00;
    acc = 8'h00;
    fval = 8'h00;
    repeat (2) @(posedge clk);
    chk("reset ctrl", {7'h0, ctrl}, 32'h0);
    chk("reset ready", {31'h0, pready}, 32'h0);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("halted ctrl", {7'h0, ctrl}, 32'h0);
    $display("reset test done");
    apb(1'b1, BOC_ADDR_CTRL, 32'h1, rd, er);
    apb(1'b0, BOC_ADDR_CTRL, 32'h0, rd, er);
    chk("run bit", rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("register test done");
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      fetch <= rows[i].instr;
      ptr <= rows[i].ptr;
      acc <= rows[i].acc;
      fval <= rows[i].fv;
      repeat (2) @(posedge clk);
      chk("ctrl", {7'h0, ctrl.acc_write, ctrl.file_write, ctrl.addr_indirect, ctrl.operand_sfr,
          ctrl.file_addr, ctrl.flag_write, ctrl.flag_value & rows[i].flw, ctrl.result,
          ctrl.instr_latch_strobe, ctrl.counter_advance}, {7'h0, rows[i][22:0], 2'b11});
      @(negedge clk);
      chk("stored", {24'h0, stored}, {24'h0, rows[i].res});
    end
    $display("instruction table done");
    @(posedge clk);
    fetch <= 12'hfff;
    repeat (2) @(posedge clk);
    chk("unknown op", {25'h0, ctrl.acc_write, ctrl.file_write, ctrl.flag_write,
        ctrl.instr_latch_strobe, ctrl.counter_advance}, 32'h3);
    apb(1'b0, BOC_ADDR_STAT, 32'h0, rd, er);
    chk("exec state", {31'h0, rd[0]}, 32'h1);
    apb(1'b1, BOC_ADDR_CTRL, 32'h0, rd, er);
    repeat (3) @(posedge clk);
    chk("stopped ctrl", {7'h0, ctrl}, 32'h0);
    apb(1'b0, BOC_ADDR_STAT, 32'h0, rd, er);
    chk("halt state", {31'h0, rd[0]}, 32'h0);
    $display("halt test done");
    stop_test();
  end
endmodule
